/* bench/core_model.sv */
// processor core stand-in: runs a handler after each dispatch and reports done
module core_model (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic pc_load,
   input wire logic in_service,
   input wire logic [3:0] gap,
   output logic core_handler_done
);
   timeunit 1ns;
   timeprecision 100ps;
   int cnt;
   initial core_handler_done = 1'b0;
   // reset loads leave in_service low, so only real handlers are timed
   always @(posedge clk) begin
      core_handler_done <= 1'b0;
      if (sys_rst) begin
         cnt <= 0;
      end else if (pc_load && in_service) begin
         cnt <= gap + 1;
      end else if (cnt == 1) begin
         core_handler_done <= 1'b1;
         cnt <= 0;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end
   end
endmodule

/* bench/testbench.sv */
// self-checking bench for the vector map
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import ivmap_pkg::*;
   logic clk, sys_rst, fuse, legacy, vbs, gie, pin_n, por, bor, wdr, done;
   logic pc_load, in_reset, irq_pending, in_service, ce;
   logic [ADDR_W-1:0] start, pc_addr;
   logic [VEC_W-1:0] vec_num;
   logic [NUM_IRQ-1:0] req;
   logic [3:0] gap;
   int n_fail = 0;
   int n_compared = 0;
   int cycles = 0;

   vector_map #(.N(NUM_IRQ)) uut (
      .clk(clk), .sys_rst(sys_rst), .ce(ce), .reset_pin_n(pin_n),
      .power_on_reset(por), .brown_out_reset(bor), .watchdog_reset(wdr),
      .boot_reset_fuse(fuse), .legacy_mode_fuse(legacy), .boot_start_addr(start),
      .vector_base_select(vbs), .ext_pin_request(req[7:0]),
      .timer2_match_request(req[8]), .timer2_wrap_request(req[9]),
      .timer1_capture_request(req[10]), .timer1_match_a_request(req[11]),
      .timer1_match_b_request(req[12]), .timer1_wrap_request(req[13]),
      .timer0_match_request(req[14]), .timer0_wrap_request(req[15]),
      .spi_done_request(req[16]), .serial0_rx_done_request(req[17]),
      .serial0_tx_holding_empty_request(req[18]), .serial0_tx_done_request(req[19]),
      .converter_done_request(req[20]), .eeprom_idle_request(req[21]),
      .comparator_request(req[22]), .timer1_match_c_request(req[23]),
      .timer3_capture_request(req[24]), .timer3_match_a_request(req[25]),
      .timer3_match_b_request(req[26]), .timer3_match_c_request(req[27]),
      .timer3_wrap_request(req[28]), .serial1_rx_done_request(req[29]),
      .serial1_tx_holding_empty_request(req[30]), .serial1_tx_done_request(req[31]),
      .two_wire_request(req[32]), .self_program_idle_request(req[33]),
      .core_irq_enable(gie), .core_handler_done(done),
      .pc_load(pc_load), .pc_addr(pc_addr), .vec_num(vec_num),
      .in_reset(in_reset), .irq_pending(irq_pending), .in_service(in_service)
   );

   core_model core (
      .clk(clk), .sys_rst(sys_rst), .pc_load(pc_load), .in_service(in_service),
      .gap(gap), .core_handler_done(done)
   );

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic report_and_stop();
      if (n_fail == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // a hang anywhere ends the run as a failure
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_fail++;
         report_and_stop();
      end
   end

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic do_reset(input logic f, input logic l, input logic [15:0] s);
      fuse = f;
      legacy = l;
      start = s;
      sys_rst = 1'b1;
      step(6);
      sys_rst = 1'b0;
   endtask

   // waits for a load, checks it, drops requests and lets the handler finish
   task automatic wait_load(input logic [15:0] exp_addr, input logic [15:0] exp_num);
      int k;
      k = 0;
      while (pc_load !== 1'b1 && k < 20) begin
         step(1);
         k++;
      end
      chk("pc_load", 16'h0001, {15'h0000, pc_load});
      chk("pc_addr", exp_addr, pc_addr);
      chk("vec_num", exp_num, {10'h000, vec_num});
      // a reset load comes from the boot step, where nothing is reported pending
      chk("irq_pending", {15'h0000, exp_num != 16'h0001}, {15'h0000, irq_pending});
      req = '0;
      k = 0;
      step(1);
      while (in_service === 1'b1 && k < 20) begin
         step(1);
         k++;
      end
      chk("in_service", 16'h0000, {15'h0000, in_service});
   endtask

   task automatic no_load(input int n);
      repeat (n) begin
         step(1);
         chk("pc_load", 16'h0000, {15'h0000, pc_load});
      end
   endtask

   task automatic t_map();
      for (int i = 0; i < NUM_IRQ; i++) begin
         gap = 4'(i % 8);
         req[i] = 1'b1;
         wait_load(16'h0002 + 16'(2 * i), 16'(i + 2));
      end
   endtask

   task automatic t_boot();
      do_reset(1'b0, 1'b0, 16'hf000);
      wait_load(16'hf000, 16'h0001);
      vbs = 1'b1;
      req[IDX_TIMER0_MATCH] = 1'b1;
      wait_load(16'hf01e, 16'h0010);
      vbs = 1'b0;
   endtask

   task automatic t_legacy();
      do_reset(1'b1, 1'b1, 16'hf000);
      wait_load(16'h0000, 16'h0001);
      req[IDX_SELF_PROGRAM_IDLE] = 1'b1;
      req[IDX_TIMER1_MATCH_C] = 1'b1;
      no_load(12);
      chk("irq_pending", 16'h0000, {15'h0000, irq_pending});
      req[IDX_COMPARATOR] = 1'b1;
      wait_load(16'h002e, 16'h0018);
   endtask

   // a request must wait for the core enable, and all state must freeze while ce is low
   task automatic t_hold();
      gie = 1'b0;
      req[IDX_TIMER2_MATCH] = 1'b1;
      no_load(4);
      chk("irq_pending", 16'h0001, {15'h0000, irq_pending});
      ce = 1'b0;
      gie = 1'b1;
      no_load(4);
      chk("in_service", 16'h0000, {15'h0000, in_service});
      ce = 1'b1;
      wait_load(16'h0012, 16'h000a);
   endtask

   // every reset cause in turn must bring back the reset vector
   task automatic t_causes();
      for (int c = 0; c < 4; c++) begin
         pin_n = (c != 0);
         por = (c == 1);
         bor = (c == 2);
         wdr = (c == 3);
         step(3);
         pin_n = 1'b1;
         por = 1'b0;
         bor = 1'b0;
         wdr = 1'b0;
         chk("in_reset", 16'h0001, {15'h0000, in_reset});
         wait_load(16'h0000, 16'h0001);
      end
   endtask

   initial begin
      vbs = 1'b0;
      gie = 1'b1;
      ce = 1'b1;
      pin_n = 1'b1;
      por = 1'b0;
      bor = 1'b0;
      wdr = 1'b0;
      req = '0;
      gap = 4'h0;
      do_reset(1'b1, 1'b0, 16'h0000);
      wait_load(16'h0000, 16'h0001);
      t_map();
      t_hold();
      t_boot();
      t_legacy();
      t_causes();
      report_and_stop();
   end
endmodule

/* bench/vector_map_chk.sv */
// port-level assertions for the vector map, bound into the top module
module vector_map_chk #(
   parameter int N = 34
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic boot_reset_fuse,
   input wire logic legacy_mode_fuse,
   input wire logic [ivmap_pkg::ADDR_W-1:0] boot_start_addr,
   input wire logic vector_base_select,
   input wire logic timer1_match_c_request,
   input wire logic timer3_match_b_request,
   input wire logic self_program_idle_request,
   input wire logic pc_load,
   input wire logic [ivmap_pkg::ADDR_W-1:0] pc_addr,
   input wire logic [ivmap_pkg::VEC_W-1:0] vec_num,
   input wire logic in_reset
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_reset_first_load: assert property ($fell(in_reset) |-> pc_load && vec_num == 6'h01)
      else $error("reset release without reset vector load");
   a_reset_addr_sel: assert property (pc_load && vec_num == 6'h01 |->
      pc_addr == (boot_reset_fuse ? 16'h0000 : boot_start_addr))
      else $error("reset vector address wrong");
   a_app_vec_addr: assert property (pc_load && vec_num != 6'h01 && !$past(vector_base_select) |->
      pc_addr == {9'h000, vec_num - 6'h01, 1'b0})
      else $error("interrupt vector address wrong with base zero");
   a_boot_vec_addr: assert property (pc_load && vec_num != 6'h01 && $past(vector_base_select) |->
      pc_addr == boot_start_addr + {9'h000, vec_num - 6'h01, 1'b0})
      else $error("interrupt vector address wrong with boot base");
   a_match_c_slot: assert property (pc_load && vec_num == 6'h19 |->
      $past(timer1_match_c_request) && pc_addr[7:0] == 8'h30)
      else $error("vector 25 not tied to timer1 match c");
   a_match_b_slot: assert property (pc_load && vec_num == 6'h1c |->
      $past(timer3_match_b_request) && pc_addr[7:0] == 8'h36)
      else $error("vector 28 not tied to timer3 match b");
   a_store_idle_slot: assert property (pc_load && vec_num == 6'h23 |->
      $past(self_program_idle_request) && pc_addr[7:0] == 8'h44)
      else $error("vector 35 not tied to self program idle");
   a_legacy_no_ext: assert property (legacy_mode_fuse && pc_load |-> vec_num < 6'h19)
      else $error("extended vector taken in legacy mode");
endmodule

bind vector_map vector_map_chk #(.N(N)) chk (
   .clk(clk),
   .sys_rst(sys_rst),
   .boot_reset_fuse(boot_reset_fuse),
   .legacy_mode_fuse(legacy_mode_fuse),
   .boot_start_addr(boot_start_addr),
   .vector_base_select(vector_base_select),
   .timer1_match_c_request(timer1_match_c_request),
   .timer3_match_b_request(timer3_match_b_request),
   .self_program_idle_request(self_program_idle_request),
   .pc_load(pc_load),
   .pc_addr(pc_addr),
   .vec_num(vec_num),
   .in_reset(in_reset)
);

/* rtl/ivmap_pkg.sv */
// shared constants, types and address function for the interrupt vector map
package ivmap_pkg;

   localparam int VEC_W = 6;
   localparam int ADDR_W = 16;
   localparam int NUM_IRQ = 34;
   localparam int MAX_IRQ = 62;
   localparam int EXT_PIN_COUNT = 8;

   localparam logic [VEC_W-1:0] RESET_VEC = 6'h01;
   localparam logic [VEC_W-1:0] FIRST_IRQ_VEC = 6'h02;
   localparam logic [VEC_W-1:0] LAST_IRQ_VEC = 6'h23;
   localparam logic [VEC_W-1:0] LAST_LEGACY_VEC = 6'h18;
   localparam logic [ADDR_W-1:0] APP_BASE = 16'h0000;

   // bit position of each source in the pending word (vector number minus two)
   localparam int IDX_EXT_PIN0 = 0;
   localparam int IDX_TIMER2_MATCH = 8;
   localparam int IDX_TIMER2_WRAP = 9;
   localparam int IDX_TIMER1_CAPTURE = 10;
   localparam int IDX_TIMER1_MATCH_A = 11;
   localparam int IDX_TIMER1_MATCH_B = 12;
   localparam int IDX_TIMER1_WRAP = 13;
   localparam int IDX_TIMER0_MATCH = 14;
   localparam int IDX_TIMER0_WRAP = 15;
   localparam int IDX_SPI_DONE = 16;
   localparam int IDX_SERIAL0_RX_DONE = 17;
   localparam int IDX_SERIAL0_TX_HOLDING_EMPTY = 18;
   localparam int IDX_SERIAL0_TX_DONE = 19;
   localparam int IDX_CONVERTER_DONE = 20;
   localparam int IDX_EEPROM_IDLE = 21;
   localparam int IDX_COMPARATOR = 22;
   localparam int IDX_TIMER1_MATCH_C = 23;
   localparam int IDX_TIMER3_CAPTURE = 24;
   localparam int IDX_TIMER3_MATCH_A = 25;
   localparam int IDX_TIMER3_MATCH_B = 26;
   localparam int IDX_TIMER3_MATCH_C = 27;
   localparam int IDX_TIMER3_WRAP = 28;
   localparam int IDX_SERIAL1_RX_DONE = 29;
   localparam int IDX_SERIAL1_TX_HOLDING_EMPTY = 30;
   localparam int IDX_SERIAL1_TX_DONE = 31;
   localparam int IDX_TWO_WIRE = 32;
   localparam int IDX_SELF_PROGRAM_IDLE = 33;

   typedef enum logic [1:0] {
      ST_HOLD = 2'b00,
      ST_BOOT = 2'b01,
      ST_IDLE = 2'b10,
      ST_BUSY = 2'b11
   } vmap_state_t;

   // two program words per vector slot, counted from the selected base
   function automatic logic [ADDR_W-1:0] vec_addr(input logic [VEC_W-1:0] num, input logic [ADDR_W-1:0] base);
      logic [VEC_W-1:0] idx;
      idx = num - RESET_VEC;
      return base + {{(ADDR_W-VEC_W-1){1'b0}}, idx, 1'b0};
   endfunction

   // slots above the legacy table vanish in compatibility mode
   function automatic logic vec_is_extended(input logic [VEC_W-1:0] num);
      return num > LAST_LEGACY_VEC;
   endfunction

endpackage

/* rtl/vec_address_calc.sv */
// turns a vector number and a base into a program word address
module vec_address_calc (
   vec_path_if.calc path
);
   import ivmap_pkg::*;

   assign path.addr = vec_addr(path.num, path.base); // [RULE16]

endmodule

/* rtl/vec_path_if.sv */
// pending word, chosen vector and address between the map's own modules
interface vec_path_if #(parameter int N = ivmap_pkg::NUM_IRQ);
   logic [N-1:0] pending;
   logic hit;
   logic [ivmap_pkg::VEC_W-1:0] num;
   logic [ivmap_pkg::ADDR_W-1:0] base;
   logic [ivmap_pkg::ADDR_W-1:0] addr;
   modport enc(input pending, output hit, output num);
   modport calc(input num, input base, output addr);
   modport ctl(output pending, output base, input hit, input num, input addr);
endinterface

/* rtl/vec_priority_pick.sv */
// picks the lowest-numbered pending source and reports its vector number
module vec_priority_pick #(
   parameter int N = ivmap_pkg::NUM_IRQ
) (
   vec_path_if.enc path
);
   import ivmap_pkg::*;

   generate
      if (N < 1 || N > MAX_IRQ) begin : g_bad_count
         $error("vec_priority_pick: source count out of range");
      end
   endgenerate

   // scan from the top so the lowest index is the last to win
   always_comb begin
      path.hit = 1'b0;
      path.num = RESET_VEC;
      for (int i = N - 1; i >= 0; i--) begin
         if (path.pending[i]) begin
            path.hit = 1'b1;
            path.num = FIRST_IRQ_VEC + VEC_W'(i);
         end
      end
   end

endmodule

/* rtl/vector_map.sv */
// reset and interrupt vector map with program counter load toward the core
//
// Contract
// RULE1 - every reset cause loads vector 1 at program address 0x0000
// RULE2 - external pin requests 0 to 7 use vectors 2 to 9, 0x0002 to 0x0010
// RULE3 - timer2 match 0x0012, timer2 wrap 0x0014, timer1 capture 0x0016, match a 0x0018
// RULE4 - timer1 match b 0x001A, timer1 wrap 0x001C, timer0 match 0x001E, wrap 0x0020
// RULE5 - spi transfer done 0x0022, serial unit 0 receive done 0x0024
// RULE6 - serial 0 holding empty 0x0026, sent 0x0028, converter 0x002A, eeprom 0x002C, comparator 0x002E
// RULE7 - timer1 match c uses vector 25 at 0x0030
// RULE8 - timer3 capture 0x0032, timer3 match a 0x0034
// RULE9 - timer3 match b uses vector 28 at 0x0036
// RULE10 - timer3 match c 0x0038, timer3 wrap 0x003A, serial 1 receive done 0x003C
// RULE11 - serial 1 holding empty 0x003E, sent 0x0040, two-wire 0x0042
// RULE12 - self-program idle uses last vector 35 at 0x0044
// RULE13 - programmed boot reset fuse moves the reset vector to the boot start
// RULE14 - base select set moves every interrupt vector up by the boot start
// RULE15 - legacy mode removes vectors 0x0030 to 0x0044 entirely
// RULE16 - address equals base plus two times vector number minus one
module vector_map #(
   parameter int N = ivmap_pkg::NUM_IRQ
) (
   input logic clk,
   input logic sys_rst,
   input logic ce,
   input logic reset_pin_n,
   input logic power_on_reset,
   input logic brown_out_reset,
   input logic watchdog_reset,
   input logic boot_reset_fuse,
   input logic legacy_mode_fuse,
   input logic [ivmap_pkg::ADDR_W-1:0] boot_start_addr,
   input logic vector_base_select,
   input logic [ivmap_pkg::EXT_PIN_COUNT-1:0] ext_pin_request,
   input logic timer2_match_request,
   input logic timer2_wrap_request,
   input logic timer1_capture_request,
   input logic timer1_match_a_request,
   input logic timer1_match_b_request,
   input logic timer1_match_c_request,
   input logic timer1_wrap_request,
   input logic timer0_match_request,
   input logic timer0_wrap_request,
   input logic timer3_capture_request,
   input logic timer3_match_a_request,
   input logic timer3_match_b_request,
   input logic timer3_match_c_request,
   input logic timer3_wrap_request,
   input logic spi_done_request,
   input logic serial0_rx_done_request,
   input logic serial0_tx_holding_empty_request,
   input logic serial0_tx_done_request,
   input logic serial1_rx_done_request,
   input logic serial1_tx_holding_empty_request,
   input logic serial1_tx_done_request,
   input logic converter_done_request,
   input logic eeprom_idle_request,
   input logic comparator_request,
   input logic two_wire_request,
   input logic self_program_idle_request,
   input logic core_irq_enable,
   input logic core_handler_done,
   output logic pc_load,
   output logic [ivmap_pkg::ADDR_W-1:0] pc_addr,
   output logic [ivmap_pkg::VEC_W-1:0] vec_num,
   output logic in_reset,
   output logic irq_pending,
   output logic in_service
);
   import ivmap_pkg::*;

   generate
      if (N != NUM_IRQ) begin : g_bad_count
         $error("vector_map: source wiring covers exactly the documented source count");
      end
   endgenerate

   // ---------------------------------------------------------------------------------------------
   // pin synchronisers: external requests and the reset pin arrive from outside the clock domain
   // ---------------------------------------------------------------------------------------------
   logic [EXT_PIN_COUNT:0] sync1_ff;
   logic [EXT_PIN_COUNT:0] sync2_ff;
   logic [EXT_PIN_COUNT:0] nxt_sync1;
   logic [EXT_PIN_COUNT:0] nxt_sync2;

   always_comb begin
      nxt_sync1 = {reset_pin_n, ext_pin_request};
      nxt_sync2 = sync1_ff;
   end

   // reset pin idles high in the chain so a released reset is not seen as a new one
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sync1_ff <= {1'b1, {EXT_PIN_COUNT{1'b0}}};
         sync2_ff <= {1'b1, {EXT_PIN_COUNT{1'b0}}};
      end else if (ce) begin
         sync1_ff <= nxt_sync1;
         sync2_ff <= nxt_sync2;
      end
   end

   logic [EXT_PIN_COUNT-1:0] ext_pin_sync;
   logic reset_pin_sync_n;
   logic any_reset;

   assign ext_pin_sync = sync2_ff[EXT_PIN_COUNT-1:0];
   assign reset_pin_sync_n = sync2_ff[EXT_PIN_COUNT];
   // all four causes share one vector, so they merge before the sequencer
   assign any_reset = ~reset_pin_sync_n | power_on_reset | brown_out_reset | watchdog_reset; // [RULE1]

   // ---------------------------------------------------------------------------------------------
   // gather the sources into one pending word, ordered by vector number
   // ---------------------------------------------------------------------------------------------
   logic [N-1:0] raw_req;

   always_comb begin
      raw_req = '0;
      raw_req[IDX_EXT_PIN0 +: EXT_PIN_COUNT] = ext_pin_sync; // [RULE2]
      raw_req[IDX_TIMER2_MATCH] = timer2_match_request; // [RULE3]
      raw_req[IDX_TIMER2_WRAP] = timer2_wrap_request; // [RULE3]
      raw_req[IDX_TIMER1_CAPTURE] = timer1_capture_request; // [RULE3]
      raw_req[IDX_TIMER1_MATCH_A] = timer1_match_a_request; // [RULE3]
      raw_req[IDX_TIMER1_MATCH_B] = timer1_match_b_request; // [RULE4]
      raw_req[IDX_TIMER1_WRAP] = timer1_wrap_request; // [RULE4]
      raw_req[IDX_TIMER0_MATCH] = timer0_match_request; // [RULE4]
      raw_req[IDX_TIMER0_WRAP] = timer0_wrap_request; // [RULE4]
      raw_req[IDX_SPI_DONE] = spi_done_request; // [RULE5]
      raw_req[IDX_SERIAL0_RX_DONE] = serial0_rx_done_request; // [RULE5]
      raw_req[IDX_SERIAL0_TX_HOLDING_EMPTY] = serial0_tx_holding_empty_request; // [RULE6]
      raw_req[IDX_SERIAL0_TX_DONE] = serial0_tx_done_request; // [RULE6]
      raw_req[IDX_CONVERTER_DONE] = converter_done_request; // [RULE6]
      raw_req[IDX_EEPROM_IDLE] = eeprom_idle_request; // [RULE6]
      raw_req[IDX_COMPARATOR] = comparator_request; // [RULE6]
      raw_req[IDX_TIMER1_MATCH_C] = timer1_match_c_request; // [RULE7]
      raw_req[IDX_TIMER3_CAPTURE] = timer3_capture_request; // [RULE8]
      raw_req[IDX_TIMER3_MATCH_A] = timer3_match_a_request; // [RULE8]
      raw_req[IDX_TIMER3_MATCH_B] = timer3_match_b_request; // [RULE9]
      raw_req[IDX_TIMER3_MATCH_C] = timer3_match_c_request; // [RULE10]
      raw_req[IDX_TIMER3_WRAP] = timer3_wrap_request; // [RULE10]
      raw_req[IDX_SERIAL1_RX_DONE] = serial1_rx_done_request; // [RULE10]
      raw_req[IDX_SERIAL1_TX_HOLDING_EMPTY] = serial1_tx_holding_empty_request; // [RULE11]
      raw_req[IDX_SERIAL1_TX_DONE] = serial1_tx_done_request; // [RULE11]
      raw_req[IDX_TWO_WIRE] = two_wire_request; // [RULE11]
      raw_req[IDX_SELF_PROGRAM_IDLE] = self_program_idle_request; // [RULE12]
   end

   // ---------------------------------------------------------------------------------------------
   // straps, caught once per reset release and held until the next reset
   // ---------------------------------------------------------------------------------------------
   logic boot_fuse_ff;
   logic legacy_ff;
   logic [ADDR_W-1:0] boot_start_ff;
   logic nxt_boot_fuse;
   logic nxt_legacy;
   logic [ADDR_W-1:0] nxt_boot_start;

   vmap_state_t state_ff;
   vmap_state_t nxt_state;

   always_comb begin
      nxt_boot_fuse = boot_fuse_ff;
      nxt_legacy = legacy_ff;
      nxt_boot_start = boot_start_ff;
      if (state_ff == ST_HOLD && !any_reset) begin
         nxt_boot_fuse = boot_reset_fuse;
         nxt_legacy = legacy_mode_fuse;
         nxt_boot_start = boot_start_addr;
      end
   end

   // unprogrammed fuse reads as one, so the reset value keeps the application reset vector
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         boot_fuse_ff <= 1'b1;
         legacy_ff <= 1'b0;
         boot_start_ff <= APP_BASE;
      end else if (ce) begin
         boot_fuse_ff <= nxt_boot_fuse;
         legacy_ff <= nxt_legacy;
         boot_start_ff <= nxt_boot_start;
      end
   end

   // ---------------------------------------------------------------------------------------------
   // selection path: mask, pick the winner, form its address
   // ---------------------------------------------------------------------------------------------
   vec_path_if #(.N(N)) path ();

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_mask
         // masked rather than renumbered, so a legacy build never lands on a missing slot
         assign path.pending[g] = raw_req[g] & ~(legacy_ff & vec_is_extended(FIRST_IRQ_VEC + VEC_W'(g))); // [RULE15]
      end
   endgenerate

   // base select is a live control level, so a change applies to the next acceptance
   assign path.base = vector_base_select ? boot_start_ff : APP_BASE; // [RULE14]

   vec_priority_pick #(
      .N(N)
   ) u_pick (
      .path(path)
   );

   vec_address_calc u_calc (
      .path(path)
   );

   logic [ADDR_W-1:0] reset_addr;
   assign reset_addr = vec_addr(RESET_VEC, boot_fuse_ff ? APP_BASE : boot_start_ff); // [RULE13]

   // ---------------------------------------------------------------------------------------------
   // sequencer and registered outputs toward the core
   // ---------------------------------------------------------------------------------------------
   logic pc_load_ff;
   logic [ADDR_W-1:0] pc_addr_ff;
   logic [VEC_W-1:0] vec_num_ff;
   logic in_reset_ff;
   logic irq_pending_ff;
   logic in_service_ff;
   logic nxt_pc_load;
   logic [ADDR_W-1:0] nxt_pc_addr;
   logic [VEC_W-1:0] nxt_vec_num;
   logic nxt_in_reset;
   logic nxt_irq_pending;
   logic nxt_in_service;

   always_comb begin
      nxt_state = state_ff;
      nxt_pc_load = 1'b0;
      nxt_pc_addr = pc_addr_ff;
      nxt_vec_num = vec_num_ff;
      nxt_in_reset = in_reset_ff;
      nxt_in_service = in_service_ff;
      nxt_irq_pending = 1'b0;
      if (any_reset) begin
         // a reset cause aborts any handler in progress and waits for release
         nxt_state = ST_HOLD;
         nxt_in_reset = 1'b1;
         nxt_in_service = 1'b0;
      end else begin
         unique case (state_ff)
            ST_HOLD: begin
               nxt_state = ST_BOOT;
            end
            ST_BOOT: begin
               nxt_pc_load = 1'b1;
               nxt_pc_addr = reset_addr; // [RULE1]
               nxt_vec_num = RESET_VEC; // [RULE1]
               nxt_in_reset = 1'b0;
               nxt_state = ST_IDLE;
            end
            ST_IDLE: begin
               nxt_irq_pending = path.hit;
               if (path.hit && core_irq_enable) begin
                  nxt_pc_load = 1'b1;
                  nxt_pc_addr = path.addr; // [RULE16]
                  nxt_vec_num = path.num;
                  nxt_in_service = 1'b1;
                  nxt_state = ST_BUSY;
               end
            end
            ST_BUSY: begin
               // no nesting: further requests wait until the handler reports done
               nxt_irq_pending = path.hit;
               if (core_handler_done) begin
                  nxt_in_service = 1'b0;
                  nxt_state = ST_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_ff <= ST_HOLD;
         pc_load_ff <= 1'b0;
         pc_addr_ff <= APP_BASE;
         vec_num_ff <= RESET_VEC;
         in_reset_ff <= 1'b1;
         irq_pending_ff <= 1'b0;
         in_service_ff <= 1'b0;
      end else if (ce) begin
         state_ff <= nxt_state;
         pc_load_ff <= nxt_pc_load;
         pc_addr_ff <= nxt_pc_addr;
         vec_num_ff <= nxt_vec_num;
         in_reset_ff <= nxt_in_reset;
         irq_pending_ff <= nxt_irq_pending;
         in_service_ff <= nxt_in_service;
      end
   end

   assign pc_load = pc_load_ff;
   assign pc_addr = pc_addr_ff;
   assign vec_num = vec_num_ff;
   assign in_reset = in_reset_ff;
   assign irq_pending = irq_pending_ff;
   assign in_service = in_service_ff;

endmodule
